// ===== common/ebt_defs.svh
// Purpose: Constants for the external bus cycle timing engine.
// Assumes: One system clock of 200 MHz drives every bus cycle.
// Notes: Offsets do not exist; all settings arrive as plain ports.
//
// What this block does
// [RULE1] A cycle with no waits lasts exactly three clocks.
// [RULE2] Bus cycles are timed from the system clock only.
// [RULE3] Separate mode internal access: address held, data floated, no strobe.
// [RULE4] Multiplexed mode internal access produces no latch pulse.
// [RULE5] Multiplexed internal access floats shared lines, keeps upper address.
// [RULE6] Zero to seven automatic wait clocks per chip-select block.
// [RULE7] Wait input stretches cycle in two-clock steps when enabled.
// [RULE8] Auto wait count and external enable come from the block wait field.
// [RULE9] Port function bit set turns the wait pin into a ready pin.
// [RULE10] Ready is inverted internally, so ready low means wait.
// [RULE11] Wait sampled just before end of auto and each two-clock period.
// [RULE12] Separate mode, select bit 1: strobe two clocks after address.
// [RULE13] Select bit 0: strobe one clock after address; no latch pulse in separate mode.
// [RULE14] Multiplexed latch pulse lasts one or two clocks, default two.
// [RULE15] The delay setting is global, not per block.
// [RULE16] Recovery cycles only between consecutive external accesses.
// [RULE17] Per block read and write recovery of zero, one or two clocks.
// [RULE18] Per block optional one-clock chip-select recovery.
// [RULE19] Mode strap low at reset selects separate, high multiplexed.
// [RULE20] Per block width and recovery; read or write recovery never over two clocks.
// [RULE21] Wait still asserted at a sample adds two clocks, then resamples.
// [RULE22] After waits, strobe released and cycle ends in its final clock.
`ifndef EBT_DEFS_SVH
`define EBT_DEFS_SVH

`define EBT_CLK_PERIOD_NS 5
`define EBT_BASE_CLOCKS 3
`define EBT_AW_W 3
`define EBT_RCV_W 2
`define EBT_RCV_MAX 2'h2
`define EBT_XWAIT_STEP 4'h2
`define EBT_SEL_RESET 1'b1
`define EBT_STRAP_SETTLE 2'h2
`define EBT_CNT_W 4
`define EBT_HLP_W 6

`endif

// ===== common/ebt_pkg.sv
// Purpose: Types for the external bus cycle timing engine.
// Assumes: Nothing beyond the constants header.
// Notes: States are one-hot.
package ebt_pkg;

  typedef enum logic [6:0] {
    EBT_IDLE = 7'h01,
    EBT_RCV = 7'h02,
    EBT_ADR = 7'h04,
    EBT_STB = 7'h08,
    EBT_AWT = 7'h10,
    EBT_XWT = 7'h20,
    EBT_LST = 7'h40
  } ebt_state_t;

endpackage

// ===== design/ebt_bus_timing.sv
// Purpose: Times external read and write cycles for the internal bus.
// Assumes: Block select and decode are done upstream of req_block.
// Notes: Pins are split into output, enable and input signals.
`timescale 1ns/1ps
`default_nettype none
`include "ebt_defs.svh"

module ebt_bus_timing
  import ebt_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter int NBLK = 4
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Internal request and answer.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_external,
  input wire logic [$clog2(NBLK)-1:0] req_block,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rsp_done,
  output logic [DATA_W-1:0] rsp_rdata,
  // Configuration.
  input wire logic addr_strobe_delay_sel,
  input wire logic ready_pin_select,
  input wire logic [NBLK*`EBT_AW_W-1:0] blk_auto_wait,
  input wire logic [NBLK-1:0] blk_ext_wait_en,
  input wire logic [NBLK*`EBT_RCV_W-1:0] block_read_recovery,
  input wire logic [NBLK*`EBT_RCV_W-1:0] block_write_recovery,
  input wire logic [NBLK-1:0] block_cs_recovery,
  input wire logic [NBLK-1:0] blk_bus16,
  // Status.
  output logic bus_mode_mux,
  output logic bus_mode_valid,
  // External pins.
  input wire logic bus_mode_strap,
  input wire logic wait_ready_pin,
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [DATA_W-1:0] data_out,
  output logic [1:0] data_oe,
  input wire logic [DATA_W-1:0] data_in,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [NBLK-1:0] cs_n
);

  localparam int BW = $clog2(NBLK);

  ebt_state_t state_q;
  logic [`EBT_CNT_W-1:0] cnt_q;
  logic [BW-1:0] blk_q;
  logic write_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [`EBT_CNT_W-1:0] rec_q;
  logic ext_seen_q;
  logic strap_s1_q, strap_s2_q;
  logic wait_s1_q, wait_s2_q;
  logic [1:0] stc_q;
  logic mux_q, mode_ok_q;
  logic fin_q, fin_rd_q;
  logic [DATA_W-1:0] din_q;
  logic done_q;
  logic [DATA_W-1:0] rdata_q;

  logic [`EBT_AW_W-1:0] aw_a [NBLK];
  logic [`EBT_RCV_W-1:0] rr_a [NBLK];
  logic [`EBT_RCV_W-1:0] wr_a [NBLK];

  // Per-block setting unpack.
  for (genvar b = 0; b < NBLK; b++) begin : g_blk
    assign aw_a[b] = blk_auto_wait[b*`EBT_AW_W +: `EBT_AW_W];
    assign rr_a[b] = block_read_recovery[b*`EBT_RCV_W +: `EBT_RCV_W];
    assign wr_a[b] = block_write_recovery[b*`EBT_RCV_W +: `EBT_RCV_W];
  end

  logic [`EBT_AW_W-1:0] aw_cur;
  logic ext_en_cur;
  logic wait_req;
  logic accept;
  logic acc_ext;
  logic [`EBT_RCV_W-1:0] rcv_raw;
  logic [`EBT_RCV_W-1:0] rcv_lim;
  logic [`EBT_CNT_W-1:0] rec_d;
  logic sel_two;

  assign aw_cur = aw_a[blk_q]; // RULE8
  assign ext_en_cur = blk_ext_wait_en[blk_q]; // RULE8
  assign sel_two = addr_strobe_delay_sel; // RULE15
  // Ready mode inverts the pin, so a low ready level is a wait.
  assign wait_req = ready_pin_select ? ~wait_s2_q : wait_s2_q; // RULE9 RULE10
  assign req_ready = (state_q == EBT_IDLE) && mode_ok_q && clk_en;
  assign accept = req_valid && req_ready;
  assign acc_ext = accept && req_external;

  // Recovery for the finishing cycle: read or write part clamped to two clocks, plus the chip-select clock.
  assign rcv_raw = write_q ? wr_a[blk_q] : rr_a[blk_q]; // RULE17
  assign rcv_lim = (rcv_raw > `EBT_RCV_MAX) ? `EBT_RCV_MAX : rcv_raw; // RULE20
  assign rec_d = `EBT_CNT_W'(rcv_lim)
               + `EBT_CNT_W'(block_cs_recovery[blk_q]); // RULE18

  // Two-flop synchronisers for the strap and the wait pin.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      wait_s1_q <= 1'b0;
      wait_s2_q <= 1'b0;
    end else if (clk_en) begin
      strap_s1_q <= bus_mode_strap;
      strap_s2_q <= strap_s1_q;
      wait_s1_q <= wait_ready_pin;
      wait_s2_q <= wait_s1_q;
    end
  end

  // Mode is caught once the strap has settled after reset release.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stc_q <= 2'h0;
      mux_q <= 1'b0;
      mode_ok_q <= 1'b0;
    end else if (clk_en && !mode_ok_q) begin
      if (stc_q == `EBT_STRAP_SETTLE) begin
        mux_q <= strap_s2_q; // RULE19
        mode_ok_q <= 1'b1;
      end else begin
        stc_q <= stc_q + 2'h1;
      end
    end
  end

  // Request latch; the address only moves on external accesses.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_q <= '0;
      write_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      ext_seen_q <= 1'b0;
    end else if (clk_en && acc_ext) begin
      blk_q <= req_block;
      write_q <= req_write;
      addr_q <= req_addr; // RULE3 RULE5
      wdata_q <= req_wdata;
      ext_seen_q <= 1'b1;
    end
  end

  // Cycle sequencer, counted in system clocks.
  always_ff @(posedge clk or posedge sys_rst) begin // RULE2
    if (sys_rst) begin
      state_q <= EBT_IDLE;
      cnt_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        EBT_IDLE: begin
          if (acc_ext && rec_q != '0) begin // RULE16
            state_q <= EBT_RCV;
            cnt_q <= rec_q;
          end else if (acc_ext) begin
            state_q <= EBT_ADR;
            cnt_q <= sel_two ? 4'h2 : 4'h1; // RULE12 RULE13 RULE14
          end
        end
        EBT_RCV: begin
          if (cnt_q == 4'h1) begin
            state_q <= EBT_ADR;
            cnt_q <= sel_two ? 4'h2 : 4'h1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        EBT_ADR: begin
          if (cnt_q != 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (!sel_two) begin
            state_q <= EBT_STB; // RULE13
          end else if (aw_cur != '0) begin
            state_q <= EBT_AWT; // RULE6
            cnt_q <= `EBT_CNT_W'(aw_cur);
          end else if (ext_en_cur && wait_req) begin
            state_q <= EBT_XWT; // RULE7 RULE11
            cnt_q <= `EBT_XWAIT_STEP;
          end else begin
            state_q <= EBT_LST; // RULE1 RULE12
          end
        end
        EBT_STB: begin
          if (aw_cur != '0) begin
            state_q <= EBT_AWT; // RULE6
            cnt_q <= `EBT_CNT_W'(aw_cur);
          end else if (ext_en_cur && wait_req) begin
            state_q <= EBT_XWT; // RULE11
            cnt_q <= `EBT_XWAIT_STEP;
          end else begin
            state_q <= EBT_LST; // RULE1
          end
        end
        EBT_AWT: begin
          if (cnt_q != 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (ext_en_cur && wait_req) begin
            state_q <= EBT_XWT; // RULE7 RULE11
            cnt_q <= `EBT_XWAIT_STEP;
          end else begin
            state_q <= EBT_LST;
          end
        end
        EBT_XWT: begin
          if (cnt_q != 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (wait_req) begin
            cnt_q <= `EBT_XWAIT_STEP; // RULE21
          end else begin
            state_q <= EBT_LST; // RULE11
          end
        end
        EBT_LST: begin
          state_q <= EBT_IDLE; // RULE22
          cnt_q <= '0;
        end
        default: begin
          state_q <= EBT_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Pending recovery; an internal access breaks the external run.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rec_q <= '0;
    end else if (clk_en) begin
      if (state_q == EBT_LST) begin
        rec_q <= rec_d; // RULE17 RULE18
      end else if (accept) begin
        rec_q <= '0; // RULE16
      end
    end
  end

  // Completion and read capture; data passes two flops.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fin_q <= 1'b0;
      fin_rd_q <= 1'b0;
      din_q <= '0;
      done_q <= 1'b0;
      rdata_q <= '0;
    end else if (clk_en) begin
      fin_q <= (state_q == EBT_LST) || (accept && !req_external);
      fin_rd_q <= (state_q == EBT_LST) && !write_q;
      din_q <= data_in;
      done_q <= fin_q;
      if (fin_rd_q) begin
        rdata_q <= din_q;
      end
    end
  end

  assign rsp_done = done_q;
  assign rsp_rdata = rdata_q;
  assign bus_mode_mux = mux_q;
  assign bus_mode_valid = mode_ok_q;

  // Pin decode from state registers.
  logic strobe;
  logic in_cyc;
  logic adr_ph;
  assign adr_ph = (state_q == EBT_ADR);
  assign strobe = (state_q == EBT_STB) || (state_q == EBT_AWT)
               || (state_q == EBT_XWT) || (state_q == EBT_LST);
  assign in_cyc = adr_ph || strobe;

  assign ale = mux_q && adr_ph; // RULE4 RULE13 RULE14
  assign rd_n = !(strobe && !write_q); // RULE3 RULE22
  assign wr_n = !(strobe && write_q); // RULE3 RULE22
  assign addr_out = addr_q; // RULE3 RULE5
  assign addr_oe = ext_seen_q;

  for (genvar b = 0; b < NBLK; b++) begin : g_cs
    assign cs_n[b] = !(in_cyc && blk_q == BW'(b));
  end

  always_comb begin
    data_out = wdata_q;
    data_oe = 2'h0; // RULE3 RULE5
    if (mux_q && adr_ph) begin
      data_out = addr_q[DATA_W-1:0];
      data_oe = 2'h3;
    end else if (strobe && write_q) begin
      data_oe = {blk_bus16[blk_q], 1'b1}; // RULE20
    end
  end

  // Checking helpers: clocks spent in each phase of a cycle.
  logic [`EBT_HLP_W-1:0] len_q, wt_q, aq_q, xq_q, alen_q, rcl_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      len_q <= '0;
      wt_q <= '0;
      aq_q <= '0;
      xq_q <= '0;
      alen_q <= '0;
      rcl_q <= '0;
    end else if (clk_en) begin
      if (accept) begin
        len_q <= '0;
        wt_q <= '0;
        aq_q <= '0;
        xq_q <= '0;
        alen_q <= '0;
        rcl_q <= '0;
      end else begin
        if (in_cyc) len_q <= len_q + 6'h1;
        if (state_q == EBT_AWT || state_q == EBT_XWT) wt_q <= wt_q + 6'h1;
        if (state_q == EBT_AWT) aq_q <= aq_q + 6'h1;
        if (state_q == EBT_XWT) xq_q <= xq_q + 6'h1;
        if (adr_ph) alen_q <= alen_q + 6'h1;
        if (state_q == EBT_RCV) rcl_q <= rcl_q + 6'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_last;
    clk_en && state_q == EBT_LST;
  endsequence

  sequence s_int_acc;
    clk_en && accept && !req_external;
  endsequence

  property p_base_len;
    s_last |-> len_q == 6'h2 + wt_q;
  endproperty
  a_base_len: assert property (p_base_len) // RULE1
    else $error("cycle length differs from three plus waits");

  property p_auto;
    s_last |-> aq_q == `EBT_HLP_W'(aw_cur);
  endproperty
  a_auto: assert property (p_auto) // RULE6
    else $error("automatic wait count differs from block field");

  property p_ext_even;
    s_last |-> xq_q[0] == 1'b0 && (ext_en_cur || xq_q == '0);
  endproperty
  a_ext_even: assert property (p_ext_even) // RULE7
    else $error("external wait not in two-clock steps");

  property p_adr_len;
    s_last |-> alen_q == (sel_two ? 6'h2 : 6'h1);
  endproperty
  a_adr_len: assert property (p_adr_len) // RULE12
    else $error("address to strobe delay wrong");

  property p_internal;
    s_int_acc |=> (rd_n && wr_n && !ale && data_oe == 2'h0
                   && $stable(addr_out))
      ##1 ($past(accept) || (rd_n && wr_n && !ale && data_oe == 2'h0
                             && $stable(addr_out)));
  endproperty
  a_internal: assert property (p_internal) // RULE3
    else $error("internal access disturbed the external pins");

  property p_no_ale_sep;
    !mux_q |-> !ale;
  endproperty
  a_no_ale_sep: assert property (p_no_ale_sep) // RULE13
    else $error("latch pulse driven in separate mode");

  property p_rec;
    clk_en && state_q == EBT_RCV && cnt_q == 4'h1
      |-> rcl_q < 6'h3;
  endproperty
  a_rec: assert property (p_rec) // RULE20
    else $error("recovery longer than three clocks");

  property p_xwait;
    clk_en && state_q == EBT_XWT && cnt_q == 4'h1 && wait_req
      |=> state_q == EBT_XWT && cnt_q == `EBT_XWAIT_STEP;
  endproperty
  a_xwait: assert property (p_xwait) // RULE21
    else $error("asserted wait did not add two clocks");

  property p_ready;
    clk_en && ready_pin_select && wait_s2_q
      && state_q == EBT_XWT && cnt_q == 4'h1
      |=> state_q == EBT_LST ##1 rd_n && wr_n;
  endproperty
  a_ready: assert property (p_ready) // RULE10
    else $error("ready high did not end the wait");

  property p_idle_off;
    state_q == EBT_IDLE || state_q == EBT_RCV |-> rd_n && wr_n;
  endproperty
  a_idle_off: assert property (p_idle_off) // RULE22
    else $error("strobe active outside a cycle");

endmodule

`default_nettype wire

// ===== verif/ebt_mem_model.sv
// Purpose: External memory model on the far side of the bus timing engine.
// Assumes: Read data is returned while the read strobe is low.
// Notes: Data stays valid one clock after the strobe, then shows its inverse.
`timescale 1ns/1ps
`default_nettype none

module ebt_mem_model (
  // Clock.
  input wire logic clk,
  // Bus pins from the engine.
  input wire logic [3:0] cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [23:0] addr_out,
  input wire logic [15:0] data_out,
  // Test controls.
  input wire logic rdy_mode,
  input var int wait_hold,
  // Pins back to the engine, and the last written data for the bench.
  output logic [15:0] data_in,
  output logic wait_ready_pin,
  output logic [15:0] wr_seen
);
  logic hold_q;
  logic wait_on;
  int cnt;

  always @(posedge clk) begin
    hold_q <= (rd_n === 1'b0);
    cnt <= (cs_n === 4'hF) ? 0 : cnt + 1;
    if (wr_n === 1'b0 && cs_n !== 4'hF) begin
      wr_seen <= data_out;
    end
  end

  // Released lines show the inverse so a late sample cannot match.
  assign data_in = (rd_n === 1'b0 || hold_q) ? addr_out[15:0] ^ 16'hA5C3 :
                   ~(addr_out[15:0] ^ 16'hA5C3);
  // The wait request is held for a set number of selected clocks.
  assign wait_on = (cs_n !== 4'hF) && (cnt < wait_hold);
  assign wait_ready_pin = rdy_mode ? ~wait_on : wait_on;

  initial begin
    hold_q = 1'b0;
    cnt = 0;
    wr_seen = 16'h0000;
  end
endmodule

`default_nettype wire

// ===== verif/external_bus_cycle_timing_bench.sv
// Purpose: Self-checking bench for the external bus timing engine.
// Assumes: Blocks are 16 bits wide until block 2 is made 8 bits wide in the external wait test; the model answers every read.
// Notes: A monitor measures select width, strobe delay, latch and gaps.
`timescale 1ns/1ps
`default_nettype none

module external_bus_cycle_timing_bench
  import ebt_pkg::*;
;
  logic clk, sys_rst, clk_en, req_valid, req_ready, req_write, req_external;
  logic [1:0] req_block;
  logic [23:0] req_addr, addr_out, a, a_prev;
  logic [15:0] req_wdata, rsp_rdata, data_out, data_in, wr_seen;
  logic rsp_done, sel, rps, bus_mode_mux, bus_mode_valid, strap, wpin;
  logic [11:0] aw;
  logic [7:0] rrc, wrc;
  logic [3:0] xe, csr, b16, cs_n;
  logic addr_oe, ale, rd_n, wr_n, rdy;
  logic [1:0] data_oe, oe_w;
  int n_fail, checks_done, hold, cur, gap, gap_l, len_l, dly, al, act, k;
  int rv[4] = '{2, 3, 0, 0};
  int wv[4] = '{0, 0, 1, 0};
  int cv[4] = '{0, 1, 0, 1};
  int eg[4] = '{3, 4, 2, 2};

  ebt_bus_timing i_ebt_bus_timing (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_external(req_external),
    .req_block(req_block), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_done(rsp_done), .rsp_rdata(rsp_rdata),
    .addr_strobe_delay_sel(sel), .ready_pin_select(rps),
    .blk_auto_wait(aw), .blk_ext_wait_en(xe), .block_read_recovery(rrc),
    .block_write_recovery(wrc), .block_cs_recovery(csr), .blk_bus16(b16),
    .bus_mode_mux(bus_mode_mux), .bus_mode_valid(bus_mode_valid),
    .bus_mode_strap(strap), .wait_ready_pin(wpin), .addr_out(addr_out),
    .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n));

  ebt_mem_model i_ebt_mem_model (.clk(clk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr_out(addr_out), .data_out(data_out), .rdy_mode(rdy),
    .wait_hold(hold), .data_in(data_in), .wait_ready_pin(wpin),
    .wr_seen(wr_seen));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Each sample describes the clock that just ended.
  always @(posedge clk) begin
    if (cs_n !== 4'hF) begin
      if (cur == 0) begin
        gap_l = gap;
        dly = 0;
        al = 0;
      end
      cur = cur + 1;
      if (dly == 0 && (rd_n === 1'b0 || wr_n === 1'b0)) dly = cur;
      if (ale === 1'b1) al = al + 1;
      if (wr_n === 1'b0) oe_w = data_oe;
    end else begin
      if (cur != 0) begin
        len_l = cur;
        gap = 0;
      end
      cur = 0;
      gap = gap + 1;
      if (!sys_rst && (rd_n !== 1'b1 || wr_n !== 1'b1 || data_oe !== 2'h0 ||
          ale !== 1'b0)) act = act + 1;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_req(input logic w, input logic e, input logic [1:0] b,
                        input logic [23:0] ad);
    int i;
    req_valid <= 1'b1;
    req_write <= w;
    req_external <= e;
    req_block <= b;
    req_addr <= ad;
    req_wdata <= ~ad[15:0];
    i = 0;
    do begin
      @(posedge clk);
      i = i + 1;
    end while (req_ready !== 1'b1 && i < 80);
    chk(req_ready, 1'b1);
  endtask

  task automatic xfer(input logic w, input logic e, input logic [1:0] b,
                      input logic [23:0] ad);
    int i;
    do_req(w, e, b, ad);
    req_valid <= 1'b0;
    i = 0;
    while (rsp_done !== 1'b1 && i < 80) begin
      @(posedge clk);
      i = i + 1;
    end
    chk(rsp_done, 1'b1);
    if (!w && e) chk(rsp_rdata, ad[15:0] ^ 16'hA5C3);
    if (w && e) chk(wr_seen, 16'(~ad[15:0]));
    @(posedge clk);
  endtask

  task automatic reset_dut(input logic s);
    sys_rst <= 1'b1;
    strap <= s;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk(bus_mode_valid, 1'b1);
    chk(bus_mode_mux, s);
    chk(addr_oe, 1'b0);
  endtask

  initial begin
    #100000;
    n_fail = n_fail + 1;
    complete_run;
  end

  initial begin
    {sys_rst, clk_en, sel, b16} = {1'b1, 1'b1, 1'b1, 4'hF};
    {req_valid, req_write, req_external, req_block} = '0;
    {req_addr, req_wdata, rps, aw, xe, rrc, wrc, csr, strap, rdy, oe_w} = '0;
    {n_fail, checks_done, hold, cur, gap, gap_l, len_l, dly, al, act} = '0;
    reset_dut(1'b0);
    for (k = 0; k < 2; k++) begin
      sel <= ~k[0];
      a = 24'(24'h001230 + k);
      xfer(1'b0, 1'b1, 2'h0, a);
      chk(len_l, 3);
      chk(dly, k ? 2 : 3);
      chk(al, 0);
      xfer(1'b1, 1'b1, 2'h0, a + 24'h000100);
      chk(len_l, 3);
      a_prev = addr_out;
      xfer(1'b0, 1'b0, 2'h0, 24'h00FF00);
      chk(addr_out, a_prev);
      chk(addr_oe, 1'b1);
    end
    $display("basic cycles done");
    sel <= 1'b1;
    for (k = 0; k < 8; k++) begin
      aw[5:3] <= k[2:0];
      xfer(1'b0, 1'b1, 2'h1, 24'(24'h004000 + k));
      chk(len_l, 3 + k);
    end
    $display("auto waits done");
    aw[8:6] <= 3'h2;
    xe <= 4'h4;
    for (k = 0; k < 2; k++) begin
      rps <= k[0];
      rdy <= k[0];
      b16[2] <= ~k[0];
      hold <= 0;
      repeat (4) @(posedge clk);
      xfer(1'b0, 1'b1, 2'h2, 24'(24'h005000 + k));
      chk(len_l, 5);
      hold <= 8;
      xfer(1'b1, 1'b1, 2'h2, 24'(24'h005100 + k));
      chk((len_l - 5) % 2, 0);
      chk(len_l > 5, 1'b1);
      chk(oe_w, k ? 2'h1 : 2'h3);
    end
    $display("external waits done");
    for (k = 0; k < 4; k++) begin
      rrc[7:6] <= rv[k][1:0];
      wrc[7:6] <= wv[k][1:0];
      csr[3] <= cv[k][0];
      do_req(wv[k][0], 1'b1, 2'h3, 24'(24'h006000 + k));
      do_req(1'b0, 1'b1, 2'h3, 24'(24'h006100 + k));
      req_valid <= 1'b0;
      repeat (20) @(posedge clk);
      chk(gap_l, eg[k]);
    end
    $display("recovery done");
    reset_dut(1'b1);
    for (k = 0; k < 2; k++) begin
      sel <= ~k[0];
      xfer(1'b0, 1'b1, k ? 2'h3 : 2'h0, 24'(24'h007000 + k));
      chk(len_l, 3);
      chk(al, k ? 1 : 2);
      a_prev = addr_out;
      xfer(1'b1, 1'b0, 2'h0, 24'h00FF10);
      chk(addr_out, a_prev);
    end
    chk(act, 0);
    $display("multiplexed mode done");
    complete_run;
  end
endmodule

`default_nettype wire
